// ### verification/gauge_host_model.sv
`default_nettype none
// Host side of the register port; every request launches DLY after an edge.
module gauge_host_model (
    // Clock.
    input  wire logic       ref_clk,
    // Register port.
    output var  logic [6:0] regAddr,
    output var  logic       regWrEn,
    output var  logic [7:0] regWrData,
    output var  logic       regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time DLY = 10;
    // Idle bus at time zero, so no request before reset ends.
    initial begin
        regAddr = 7'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    // One-cycle write strobe.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #DLY;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge ref_clk);
        #DLY;
        regWrEn = 1'b0;
    endtask
    // Answer is taken exactly two edges after the request edge.
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #DLY;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #DLY;
        regRdEn = 1'b0;
        @(posedge ref_clk);
        #DLY;
        d = (regRdValid === 1'b1) ? regRdData : 8'hxx;
    endtask
endmodule // gauge_host_model
`default_nettype wire

// ### verification/tb_battery_gauge_report_registers.sv
`default_nettype none
module tb_battery_gauge_report_registers;
    import gauge_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RC = 16;
    logic ref_clk = 1'b0, rst = 1'b1, regWrEn, regRdEn, regRdValid;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, b;
    logic [15:0] tempQk = 16'h0B9C, batterySenseMv = 16'h1770, w;
    logic [15:0] senseMag = 16'h0100, avgRate = 16'h0000;
    logic chargeActive = 1'b0, quantumPulse = 1'b0, ramCorrupt = 1'b1;
    int n_mismatch = 0, tests_run = 0;
    always #50 ref_clk = ~ref_clk;
    gauge_host_model i_host (.ref_clk(ref_clk), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid));
    // Short refresh keeps the run brief.
    battery_gauge_report_registers #(.REFRESH_CYCLES(RC)) i_dut (
        .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid), .tempQk(tempQk),
        .batterySenseMv(batterySenseMv), .chargeActive(chargeActive),
        .senseMag(senseMag), .avgRate(avgRate),
        .quantumPulse(quantumPulse), .ramCorrupt(ramCorrupt));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd16(input logic [6:0] a);
        logic [7:0] l;
        i_host.rd(a, l);
        i_host.rd(a + 7'h01, b);
        w = {b, l};
    endtask
    // Two full refresh periods, so every pair has reloaded.
    task automatic ticks();
        repeat (2 * RC + 4) @(posedge ref_clk);
        #10;
    endtask
    task automatic stop_test();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_measure();
        ticks();
        i_host.rd(ADDR_FLAGS, b);
        chk(b, FLAGS_RESET);
        rd16(ADDR_TEMP_LO);
        chk(w, 16'h0B9C);
        rd16(ADDR_VOLT_LO);
        chk(w, VOLT_MAX_MV);
        i_host.wr(ADDR_TEMP_LO, 8'h00);
        i_host.wr(ADDR_RSVD_A0, 8'h5A);
        rd16(ADDR_TEMP_LO);
        chk(w, 16'h0B9C);
        i_host.rd(ADDR_RSVD_A0, b);
        chk(b, 8'h00);
    endtask
    task automatic t_charge();
        chargeActive = 1'b1;
        senseMag = 16'h0000;
        repeat (82) begin
            @(posedge ref_clk) #10 quantumPulse = 1'b1;
            @(posedge ref_clk) #10 quantumPulse = 1'b0;
        end
        ticks();
        i_host.rd(ADDR_FLAGS, b);
        chk(b & 8'hC3, 8'hC0);
        rd16(ADDR_RAW_LO);
        chk(w, 16'h0052);
        rd16(ADDR_RATE_LO);
        chk(w, 16'h0052);
        rd16(ADDR_TCOMP_LO);
        chk(w, 16'h0052);
        i_host.rd(ADDR_PERCENT, b);
        chk(b, 8'h01);
    endtask
    // Reset mid-run without corruption keeps the raw count.
    task automatic t_retain();
        @(posedge ref_clk) #10 rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #10 rst = 1'b0;
        i_host.rd(ADDR_FLAGS, b);
        chk(b, FLAGS_RESET);
        ticks();
        rd16(ADDR_RAW_LO);
        chk(w, 16'h0052);
    endtask
    // Armed discharge of 32 quanta, then below both end thresholds, which
    // learns 32 + 32/16 and empties the raw count.
    task automatic t_empty();
        chargeActive = 1'b0;
        senseMag = 16'h0100;
        avgRate = 16'h0100;
        repeat (32) begin
            @(posedge ref_clk) #10 quantumPulse = 1'b1;
            @(posedge ref_clk) #10 quantumPulse = 1'b0;
        end
        ticks();
        rd16(ADDR_RAW_LO);
        chk(w, 16'h0032);
        rd16(ADDR_RATE_LO);
        chk(w, 16'h000E);
        batterySenseMv = 16'h07D0;
        ticks();
        i_host.rd(ADDR_FLAGS, b);
        chk(b, 8'h03);
        rd16(ADDR_FULL_LO);
        chk(w, 16'h0022);
        rd16(ADDR_RAW_LO);
        chk(w, 16'h0000);
        rd16(ADDR_RATE_LO);
        chk(w, 16'h0000);
    endtask
    task automatic t_key();
        i_host.wr(ADDR_NVM_LO + 7'h02, 8'h11);
        i_host.rd(ADDR_NVM_LO + 7'h02, b);
        chk(b, 8'h3C);
        i_host.wr(ADDR_KEY, KEY_VALUE);
        i_host.wr(ADDR_NVM_LO + 7'h02, 8'h11);
        i_host.rd(ADDR_NVM_LO + 7'h02, b);
        chk(b, 8'h11);
        i_host.wr(ADDR_KEY, 8'h00);
        i_host.wr(ADDR_NVM_LO + 7'h02, 8'h22);
        i_host.rd(ADDR_NVM_LO + 7'h02, b);
        chk(b, 8'h11);
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        #10 rst = 1'b0;
        ramCorrupt = 1'b0;
        t_measure();
        t_charge();
        t_retain();
        t_empty();
        t_key();
        stop_test();
    end
    // Watchdog well past the expected run length.
    initial begin
        #1_000_000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb_battery_gauge_report_registers
`default_nettype wire

// ### verilog/battery_gauge_report_registers.sv
// Summary of operation
// (RULE1) Die temperature in quarter kelvin, 16 bits, refreshed every 2 s.
// (RULE2) Battery millivolts refreshed every two seconds, saturated at 5000.
// (RULE3) Measurement, flag, percent and capacity registers ignore host writes.
// (RULE4) Unlearned flag set on full reset, cleared by learning; others reset.
// (RULE5) Charging flag bit 7 follows charge current, cleared on reset.
// (RULE6) Idle flag set while sense magnitude is below filter threshold.
// (RULE7) Taper flag: charging below taper current at qualification voltage.
// (RULE8) Qualified flag set by taper, cleared by update, charging or a light-load warning.
// (RULE9) Low warning: voltage at first threshold and capacity at most 1/16.
// (RULE10) Learned full updates when low warning rises while qualified; the code also requires avgRate above twice kStandby.
// (RULE11) Empty flag set when fully discharged, cleared on reset or charging.
// (RULE12) Percent equals 100 times raw capacity over learned full.
// (RULE13) Raw capacity counts quanta up on charge, down on discharge.
// (RULE14) Raw capacity clears when discharging at or below empty threshold.
// (RULE15) Reset clears raw capacity only when memory corruption is flagged.
// (RULE16) Rate-compensated capacity from rate and constant; never rises while discharging.
// (RULE17) Rate-compensated equals raw when charging, else min of old, new.
// (RULE18) Temperature-compensated follows rate-compensated unless cold.
// (RULE19) Writes to reserved addresses are ignored.
// (RULE20) Constant writes blocked until key value is written to key register.
// (RULE21) Both bytes of each pair update together at the refresh tick.
`default_nettype none
module battery_gauge_report_registers #(
    parameter int REFRESH_CYCLES = gauge_pkg::REFRESH_CYCLES
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register access port.
    input  wire logic [6:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output var  logic [7:0]  regRdData,
    output var  logic        regRdValid,
    // Measurement front end, same clock.
    input  wire logic [15:0] tempQk,
    input  wire logic [15:0] batterySenseMv,
    input  wire logic        chargeActive,
    input  wire logic [15:0] senseMag,
    input  wire logic [15:0] avgRate,
    input  wire logic        quantumPulse,
    input  wire logic        ramCorrupt
);
    import gauge_pkg::*;

    // ****************************************************************
    // State and helpers.
    // ****************************************************************
    typedef struct packed {
        logic [15:0] tempRep;
        logic [15:0] voltRep;
        logic [15:0] raw_capacity;
        logic [15:0] nacRep;
        logic [15:0] rate_comp_capacity;
        logic [15:0] temp_comp_capacity;
        logic [15:0] learned_full;
        logic [15:0] disCount;
        logic [7:0]  flags;
        logic [7:0]  pct;
        logic [7:0]  rdData;
        logic [6:0]  rdAddr;
        logic        unlock;
        logic        rdPend;
        logic        rdValid;
    } state_t;
    state_t s, n;

    function automatic logic [15:0] satSub(input logic [15:0] a,
                                           input logic [15:0] b);
        return (a > b) ? 16'(a - b) : 16'h0000;
    endfunction

    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [15:0] edvMv(input logic [7:0] scaled);
        return 16'((16'(scaled) + EDV_OFFSET) << EDV_SHIFT);
    endfunction

    function automatic logic [7:0] pctOf(input logic [15:0] num,
                                         input logic [15:0] den);
        logic [23:0] q;
        q = 24'h00_0000;
        if (den != 16'h0000) begin
            q = (24'(num) * PERCENT_SCALE) / 24'(den);
        end
        return (q > 24'(PERCENT_MAX)) ? PERCENT_MAX : q[7:0];
    endfunction

    // ****************************************************************
    // Sub-blocks.
    // ****************************************************************
    logic tick;
    nvm_if nvm ();

    refresh_timer #(.CYCLES(REFRESH_CYCLES)) timer (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    nvm_const_store store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .port    (nvm.mem)
    );

    // Decoded constants and thresholds.
    logic [7:0]  kFull, kFilter, kTaper, kStandby, kRate, kTemp, kPack;
    logic [15:0] emptyMv, warnMv, qualMv, rateDerate, coldThr, coldLoss;
    logic        inNvm, inRsvd, nvmWrite;

    assign kFull    = nvm.image[NVM_FULL_INIT];
    assign kFilter  = nvm.image[NVM_FILTER];
    assign kTaper   = nvm.image[NVM_TAPER];
    assign kStandby = nvm.image[NVM_STANDBY];
    assign kRate    = nvm.image[NVM_RATE_K];
    assign kTemp    = nvm.image[NVM_TEMP_K];
    assign kPack    = nvm.image[NVM_PACK_CFG];
    assign emptyMv  = edvMv(nvm.image[NVM_EMPTY_THR]);
    assign warnMv   = edvMv(nvm.image[NVM_WARN_THR]);
    // Pack config bits 1:0 select the taper qualification voltage.
    assign qualMv   = QUAL_MV[kPack[1:0]];
    // Rate loss: average rate times the rate constant, scaled down by 256.
    assign rateDerate = 16'((24'(avgRate) * 24'(kRate)) >> 8);
    // Cold limit: base point plus upper nibble of temperature constant times the step.
    assign coldThr  = 16'(TEMP_BASE_QK + 16'(kTemp[7:4]) * TEMP_STEP_QK);
    assign coldLoss = 16'((16'(kFull) * 16'(kTemp[3:0])) << 4);

    // Address classes; the store shares one address for reads and writes.
    assign inNvm  = (regAddr >= ADDR_NVM_LO) && (regAddr <= ADDR_NVM_HI);
    assign inRsvd = ((regAddr >= ADDR_RSVD_A0) && (regAddr <= ADDR_RSVD_A1))
                 || ((regAddr >= ADDR_RSVD_B0) && (regAddr <= ADDR_RSVD_B1));
    assign nvmWrite = regWrEn && inNvm && s.unlock; // RULE20
    assign nvm.wrEn   = nvmWrite;
    assign nvm.wrData = regWrData;
    assign nvm.addr   = inNvm ? 4'(regAddr - ADDR_NVM_LO) : 4'hF;

    // ****************************************************************
    // Next-state logic.
    // ****************************************************************
    // Every measurement and flag register moves only at the tick; the raw counter
    // runs every cycle so no quantum is dropped between refreshes.
    logic [15:0] rateNew, cacdNext, cactNext, nacNext;
    logic        warnNow, taperNow, warnRise, learn;

    always_comb begin
        n = s;
        rateNew  = 16'h0000;
        cacdNext = 16'h0000;
        cactNext = 16'h0000;
        warnNow  = 1'b0;
        taperNow = 1'b0;
        warnRise = 1'b0;
        learn    = 1'b0;

        // Charge integration; saturates instead of wrapping.
        nacNext = s.raw_capacity;
        if (quantumPulse) begin
            if (chargeActive) begin // RULE13
                nacNext = (s.raw_capacity == 16'hFFFF) ? s.raw_capacity : 16'(s.raw_capacity + 16'h1);
            end else begin
                nacNext = satSub(s.raw_capacity, 16'h0001); // RULE13
                if (s.flags[FLAG_QUALIFIED]) begin
                    n.disCount = (s.disCount == 16'hFFFF) ? s.disCount
                               : 16'(s.disCount + 16'h1);
                end
            end
        end
        if (!chargeActive && batterySenseMv <= emptyMv) begin
            nacNext = 16'h0000; // RULE14
        end
        n.raw_capacity = nacNext;

        if (tick) begin
            // Pairs load from one value so the bytes always match.
            n.tempRep = tempQk; // RULE1 RULE21
            n.voltRep = min16(batterySenseMv, VOLT_MAX_MV); // RULE2 RULE21
            n.nacRep  = nacNext; // RULE21
            n.pct     = pctOf(nacNext, s.learned_full); // RULE12

            n.flags[FLAG_CHARGING] = chargeActive; // RULE5
            n.flags[FLAG_IDLE] =
                senseMag < 16'({kFilter[7:4], 1'b0}); // RULE6
            taperNow = chargeActive && senseMag < 16'(kTaper)
                    && batterySenseMv >= qualMv; // RULE7
            n.flags[FLAG_TAPER] = taperNow;
            warnNow = !chargeActive && batterySenseMv <= warnMv
                   && nacNext <= (s.learned_full >> 4); // RULE9
            warnRise = warnNow && !s.flags[FLAG_LOW_WARN];
            n.flags[FLAG_LOW_WARN] = warnNow;
            n.flags[FLAG_EMPTY] =
                !chargeActive && batterySenseMv <= emptyMv; // RULE11
            n.flags[3] = 1'b0;

            // Learning: full charge arms it, light load at the warning
            // point or a new charge disarms it.
            learn = warnRise && s.flags[FLAG_QUALIFIED]
                 && avgRate > 16'({kStandby, 1'b0});
            if (taperNow) begin
                n.flags[FLAG_QUALIFIED] = 1'b1; // RULE8
                n.disCount = 16'h0000;
            end else if (learn) begin
                n.flags[FLAG_QUALIFIED] = 1'b0; // RULE8
                n.flags[FLAG_UNLEARNED] = 1'b0; // RULE4
                // The last sixteenth is still in the cell at this point.
                n.learned_full = 16'(s.disCount + (s.disCount >> 4)); // RULE10
            end else if (chargeActive || warnRise) begin
                n.flags[FLAG_QUALIFIED] = 1'b0; // RULE8
            end

            // Rate compensation only ever lowers the figure on discharge.
            rateNew = satSub(nacNext, rateDerate); // RULE16
            cacdNext = chargeActive ? nacNext
                     : min16(s.rate_comp_capacity, rateNew); // RULE17
            n.rate_comp_capacity = cacdNext;
            cactNext = (tempQk < coldThr) ? satSub(cacdNext, coldLoss)
                     : cacdNext; // RULE18
            n.temp_comp_capacity = cactNext;
        end

        // Register writes: only the key register holds host data here.
        if (regWrEn && regAddr == ADDR_KEY) begin // RULE3 RULE19
            n.unlock = (regWrData == KEY_VALUE); // RULE20
        end

        // Reads answer two cycles after the request, from a flip-flop.
        n.rdPend  = regRdEn;
        n.rdValid = s.rdPend;
        if (regRdEn) begin
            n.rdAddr = regAddr;
        end
        if (s.rdPend) begin
            case (s.rdAddr)
                ADDR_TEMP_LO:  n.rdData = s.tempRep[7:0];
                ADDR_TEMP_HI:  n.rdData = s.tempRep[15:8];
                ADDR_VOLT_LO:  n.rdData = s.voltRep[7:0];
                ADDR_VOLT_HI:  n.rdData = s.voltRep[15:8];
                ADDR_FLAGS:    n.rdData = s.flags;
                ADDR_PERCENT:  n.rdData = s.pct;
                ADDR_RAW_LO:   n.rdData = s.nacRep[7:0];
                ADDR_RAW_HI:   n.rdData = s.nacRep[15:8];
                ADDR_RATE_LO:  n.rdData = s.rate_comp_capacity[7:0];
                ADDR_RATE_HI:  n.rdData = s.rate_comp_capacity[15:8];
                ADDR_TCOMP_LO: n.rdData = s.temp_comp_capacity[7:0];
                ADDR_TCOMP_HI: n.rdData = s.temp_comp_capacity[15:8];
                ADDR_FULL_LO:  n.rdData = s.learned_full[7:0];
                ADDR_FULL_HI:  n.rdData = s.learned_full[15:8];
                default: begin
                    n.rdData = (s.rdAddr >= ADDR_NVM_LO) ? nvm.rdData
                             : 8'h00;
                end
            endcase
        end

        // Full reset; the raw counter survives unless memory is suspect.
        if (rst) begin
            n.tempRep  = 16'h0000;
            n.voltRep  = 16'h0000;
            n.nacRep   = 16'h0000;
            n.rate_comp_capacity     = 16'h0000;
            n.temp_comp_capacity     = 16'h0000;
            n.pct      = 8'h00;
            n.disCount = 16'h0000;
            n.flags    = FLAGS_RESET; // RULE4 RULE5
            n.learned_full      = {kFull, 8'h00};
            n.rdData   = 8'h00;
            n.rdAddr   = 7'h00;
            n.unlock   = 1'b0;
            n.rdPend   = 1'b0;
            n.rdValid  = 1'b0;
            n.raw_capacity      = ramCorrupt ? 16'h0000 : s.raw_capacity; // RULE15
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= n;
    end

    assign regRdData  = s.rdData;
    assign regRdValid = s.rdValid;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    sequence warnRiseQual;
        tick && warnNow && !s.flags[FLAG_LOW_WARN]
            && s.flags[FLAG_QUALIFIED] && avgRate > 16'({kStandby, 1'b0});
    endsequence

    sequence keyThenWrite;
        regWrEn && regAddr == ADDR_KEY && regWrData == KEY_VALUE
            ##1 !regWrEn ##1 regWrEn && inNvm;
    endsequence

    temp_pair_a: // RULE1
    assert property (@(posedge ref_clk) disable iff (rst)
        tick |=> s.tempRep == $past(tempQk))
        else $error("temperature pair not loaded at tick");

    volt_sat_a: // RULE2
    assert property (@(posedge ref_clk) disable iff (rst)
        tick |=> s.voltRep <= VOLT_MAX_MV
            && (s.voltRep == $past(batterySenseMv)
                || s.voltRep == VOLT_MAX_MV))
        else $error("voltage not saturated at 5000 mV");

    ro_write_a: // RULE3
    assert property (@(posedge ref_clk) disable iff (rst)
        regWrEn && !tick && regAddr >= ADDR_TEMP_LO
            && regAddr <= ADDR_FULL_HI
            |=> $stable(s.flags) && $stable(s.learned_full) && $stable(s.pct))
        else $error("read-only register changed by write");

    flags_reset_a: // RULE4
    assert property (@(posedge ref_clk)
        rst |=> s.flags == FLAGS_RESET)
        else $error("flags wrong after reset");

    charge_flag_a: // RULE5
    assert property (@(posedge ref_clk) disable iff (rst)
        tick |=> s.flags[FLAG_CHARGING] == $past(chargeActive))
        else $error("charging flag does not follow current");

    learn_update_a: // RULE10
    assert property (@(posedge ref_clk) disable iff (rst)
        warnRiseQual |=> !s.flags[FLAG_UNLEARNED]
            && !s.flags[FLAG_QUALIFIED]
            && s.learned_full == 16'($past(s.disCount) + ($past(s.disCount) >> 4)))
        else $error("learned full not updated on warning edge");

    raw_clear_a: // RULE14
    assert property (@(posedge ref_clk) disable iff (rst)
        !chargeActive && batterySenseMv <= emptyMv |=> s.raw_capacity == 16'h0000)
        else $error("raw capacity not cleared at empty threshold");

    rate_charge_a: // RULE17
    assert property (@(posedge ref_clk) disable iff (rst)
        tick && chargeActive |=> s.rate_comp_capacity == s.nacRep)
        else $error("rate capacity differs from raw while charging");

    rsvd_write_a: // RULE19
    assert property (@(posedge ref_clk) disable iff (rst)
        regWrEn && inRsvd |-> !nvmWrite ##1 $stable(s.unlock))
        else $error("reserved write had an effect");

    key_gate_a: // RULE20
    assert property (@(posedge ref_clk) disable iff (rst)
        nvmWrite |-> s.unlock && ($past(regWrEn && regAddr == ADDR_KEY
            && regWrData == KEY_VALUE) || $past(s.unlock)))
        else $error("constant write without key");

    key_open_a: // RULE20
    assert property (@(posedge ref_clk) disable iff (rst)
        keyThenWrite |-> nvmWrite)
        else $error("constant write refused after key");

endmodule // battery_gauge_report_registers
`default_nettype wire

// ### verilog/gauge_pkg.sv
`default_nettype none
package gauge_pkg;

    // ****************************************************************
    // Register map of the host-visible bank.
    // ****************************************************************
    localparam logic [6:0] ADDR_TEMP_LO  = 7'h06;
    localparam logic [6:0] ADDR_TEMP_HI  = 7'h07;
    localparam logic [6:0] ADDR_VOLT_LO  = 7'h08;
    localparam logic [6:0] ADDR_VOLT_HI  = 7'h09;
    localparam logic [6:0] ADDR_FLAGS    = 7'h0A;
    localparam logic [6:0] ADDR_PERCENT  = 7'h0B;
    localparam logic [6:0] ADDR_RAW_LO   = 7'h0C;
    localparam logic [6:0] ADDR_RAW_HI   = 7'h0D;
    localparam logic [6:0] ADDR_RATE_LO  = 7'h0E;
    localparam logic [6:0] ADDR_RATE_HI  = 7'h0F;
    localparam logic [6:0] ADDR_TCOMP_LO = 7'h10;
    localparam logic [6:0] ADDR_TCOMP_HI = 7'h11;
    localparam logic [6:0] ADDR_FULL_LO  = 7'h12;
    localparam logic [6:0] ADDR_FULL_HI  = 7'h13;
    localparam logic [6:0] ADDR_RSVD_A0  = 7'h14;
    localparam logic [6:0] ADDR_RSVD_A1  = 7'h6D;
    localparam logic [6:0] ADDR_KEY      = 7'h6E;
    localparam logic [6:0] ADDR_RSVD_B0  = 7'h6F;
    localparam logic [6:0] ADDR_RSVD_B1  = 7'h75;
    localparam logic [6:0] ADDR_NVM_LO   = 7'h76;
    localparam logic [6:0] ADDR_NVM_HI   = 7'h7F;
    localparam logic [7:0] KEY_VALUE     = 8'hDD;

    // ****************************************************************
    // Constant store layout, index = address minus the first address.
    // ****************************************************************
    localparam int NVM_WORDS = 10;
    localparam logic [3:0] NVM_FULL_INIT = 4'h0;
    localparam logic [3:0] NVM_EMPTY_THR = 4'h1;
    localparam logic [3:0] NVM_WARN_THR  = 4'h2;
    localparam logic [3:0] NVM_STANDBY   = 4'h3;
    localparam logic [3:0] NVM_FILTER    = 4'h4;
    localparam logic [3:0] NVM_TAPER     = 4'h5;
    localparam logic [3:0] NVM_PACK_CFG  = 4'h6;
    localparam logic [3:0] NVM_RATE_K    = 4'h8;
    localparam logic [3:0] NVM_TEMP_K    = 4'h9;
    // Defaults loaded on reset; the identity byte value is arbitrary.
    localparam logic [NVM_WORDS-1:0][7:0] NVM_DEFAULT = {
        8'h52, 8'h24, 8'hA5, 8'h01, 8'h20, 8'h31, 8'h05, 8'h3C,
        8'h3F, 8'h20};

    // ****************************************************************
    // Flag bit positions and reset value.
    // ****************************************************************
    localparam int FLAG_CHARGING  = 7;
    localparam int FLAG_IDLE      = 6;
    localparam int FLAG_TAPER     = 5;
    localparam int FLAG_UNLEARNED = 4;
    localparam int FLAG_QUALIFIED = 2;
    localparam int FLAG_LOW_WARN  = 1;
    localparam int FLAG_EMPTY     = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h10;

    // ****************************************************************
    // Scaling and timing.
    // ****************************************************************
    localparam logic [15:0] VOLT_MAX_MV   = 16'h1388;
    localparam logic [15:0] EDV_OFFSET    = 16'h0100;
    localparam int          EDV_SHIFT     = 3;
    localparam logic [23:0] PERCENT_SCALE = 24'h00_0064;
    localparam logic [7:0]  PERCENT_MAX   = 8'h64;
    localparam logic [15:0] TEMP_BASE_QK  = 16'h0444;
    localparam logic [15:0] TEMP_STEP_QK  = 16'h0028;
    localparam logic [3:0][15:0] QUAL_MV  = {
        16'h1068, 16'h1036, 16'h1004, 16'h0FA0};
    localparam int REFRESH_SEC    = 2;
    localparam int CLK_HZ         = 10_000_000;
    localparam int REFRESH_CYCLES = REFRESH_SEC * CLK_HZ;

endpackage
`default_nettype wire

// ### verilog/nvm_const_store.sv
`default_nettype none
module nvm_const_store (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Store port.
    nvm_if.mem        port
);
    import gauge_pkg::*;

    typedef struct packed {
        logic [NVM_WORDS-1:0][7:0] mem;
        logic [7:0]                rdData;
    } store_t;
    store_t s, n;

    // Reset stands in for the nonvolatile cells, which this model lacks.
    always_comb begin
        n = s;
        n.rdData = (port.addr < 4'(NVM_WORDS)) ? s.mem[port.addr] : 8'h00;
        if (port.wrEn && port.addr < 4'(NVM_WORDS)) begin
            n.mem[port.addr] = port.wrData;
        end
        if (rst) begin
            n.mem = NVM_DEFAULT;
            n.rdData = 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= n;
    end

    assign port.rdData = s.rdData;
    assign port.image = s.mem;
endmodule // nvm_const_store
`default_nettype wire

// ### verilog/nvm_if.sv
`default_nettype none
// Carries the constant store's write and read port and its live image.
interface nvm_if;
    logic                                    wrEn;
    logic [3:0]                              addr;
    logic [7:0]                              wrData;
    logic [7:0]                              rdData;
    logic [gauge_pkg::NVM_WORDS-1:0][7:0]    image;
    modport host (output wrEn, addr, wrData, input rdData, image);
    modport mem  (input wrEn, addr, wrData, output rdData, image);
endinterface
`default_nettype wire

// ### verilog/refresh_timer.sv
`default_nettype none
module refresh_timer #(
    parameter int CYCLES = gauge_pkg::REFRESH_CYCLES
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // One-cycle refresh strobe.
    output var  logic tick
);
    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } timer_t;
    timer_t s, n;

    // Free-running count; the strobe is registered so it is glitch free.
    always_comb begin
        n = s;
        n.tick = 1'b0;
        if (s.count >= 32'(CYCLES - 1)) begin
            n.count = '0;
            n.tick = 1'b1;
        end else begin
            n.count = s.count + 32'h0000_0001;
        end
        if (rst) begin
            n = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= n;
    end

    assign tick = s.tick;
endmodule // refresh_timer
`default_nettype wire
